// >>> sssr_core.sv
// hold-off, soft-start discharge and auto-restart sequencer
`timescale 1ns/10ps
// Function
// - hold-off pulls feedback node up
// - switches off while pull-up active
// - power-up hold-off lasts 1024 fmax cycles
// - faults and restart hold 131072 cycles
// - expiry releases pull-up, starts switching
// - hold-off counter advances on fmax clock
// - at limit, wait feedback below 2.0V
// - frequency follows feedback current
// - remote-off requests give 131072-cycle restart
// - supply restore gives only 1024 cycles
// - seven 0.5V pulses or one 0.9V
module sssr_core (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic fmax_tick,
  input wire logic supply_ok,
  input wire logic line_voltage_ok,
  input wire logic cs_pulse_low,
  input wire logic cs_pulse_high,
  input wire logic fb_current_limit,
  input wire logic fb_above_2v0,
  input wire logic osc_cycle,
  input wire logic autorestart_req,
  output logic fb_pullup_en,
  output logic switch_enable,
  output logic start_at_fmax,
  output logic holdoff_active
);
  logic [5:0] raw_in;
  logic [5:0] syn;
  logic sup_s;
  logic line_s;
  logic lo_s;
  logic hi_s;
  logic lim_s;
  logic lo_d_r;
  logic hi_d_r;
  logic lo_edge;
  logic hi_edge;
  logic [2:0] oc_cnt_r;
  logic oc_trip;
  logic fault;
  sssr_pkg::sssr_state_t state_r;
  logic [17:0] cnt_r;
  logic [17:0] target_r;
  logic expire;
  logic fb_hi_r;

  // pins are asynchronous to sys_clk
  assign raw_in = {fb_above_2v0, fb_current_limit, cs_pulse_high,
                   cs_pulse_low, line_voltage_ok, supply_ok};

  sssr_sync #(.W(6)) sssr_sync_i (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign sup_s = syn[0];
  assign line_s = syn[1];
  assign lo_s = syn[2];
  assign hi_s = syn[3];
  assign lim_s = syn[4];
  assign lo_edge = lo_s & ~lo_d_r;
  assign hi_edge = hi_s & ~hi_d_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lo_d_r <= 1'b0;
      hi_d_r <= 1'b0;
      fb_hi_r <= 1'b0;
    end else begin
      lo_d_r <= lo_s;
      hi_d_r <= hi_s;
      fb_hi_r <= syn[5];
    end
  end

  // consecutive pulse count
  // a switching cycle without a low pulse breaks the run
  always_ff @(posedge sys_clk) begin
    if (reset || state_r != sssr_pkg::SSSR_RUN) begin
      oc_cnt_r <= sssr_pkg::OC_CNT_RST;
    end else if (lo_edge) begin
      if (oc_cnt_r != sssr_pkg::OC_PULSES) begin
        oc_cnt_r <= oc_cnt_r + 3'h1;
      end
    end else if (osc_cycle && !lo_s) begin
      oc_cnt_r <= sssr_pkg::OC_CNT_RST;
    end
  end

  // trip on run of seven or one big pulse
  assign oc_trip = (lo_edge && oc_cnt_r == sssr_pkg::OC_PULSES - 3'h1)
                   || hi_edge;

  // fault by line pin low, pulse trip, sense high or restart request, only while supply ok
  assign fault = sup_s && (!line_s || oc_trip || hi_s || autorestart_req);

  // hold-off counts only on fmax ticks
  assign expire = fmax_tick && (cnt_r == target_r - 18'h00001);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= sssr_pkg::SSSR_OFF;
      cnt_r <= sssr_pkg::CNT_RST;
      target_r <= sssr_pkg::POWERUP_CYCLES;
    end else if (!sup_s) begin
      state_r <= sssr_pkg::SSSR_OFF;
      cnt_r <= sssr_pkg::CNT_RST;
    end else begin
      case (state_r)
        sssr_pkg::SSSR_OFF: begin
          state_r <= sssr_pkg::SSSR_HOLD;
          cnt_r <= sssr_pkg::CNT_RST;
          target_r <= sssr_pkg::POWERUP_CYCLES;
        end
        sssr_pkg::SSSR_HOLD: begin
          if (fault) begin
            cnt_r <= sssr_pkg::CNT_RST;
            target_r <= sssr_pkg::RESTART_CYCLES;
          end else if (expire) begin
            state_r <= sssr_pkg::SSSR_WAIT;
            cnt_r <= sssr_pkg::CNT_RST;
          end else if (fmax_tick) begin
            cnt_r <= cnt_r + 18'h00001;
          end
        end
        sssr_pkg::SSSR_WAIT: begin
          if (fault) begin
            state_r <= sssr_pkg::SSSR_HOLD;
            cnt_r <= sssr_pkg::CNT_RST;
            target_r <= sssr_pkg::RESTART_CYCLES;
          end else if (!(lim_s && fb_hi_r)) begin
            // limited start waits for node below 2.0V
            state_r <= sssr_pkg::SSSR_RUN;
          end
        end
        sssr_pkg::SSSR_RUN: begin
          if (fault) begin
            // long hold-off on trip or restart
            state_r <= sssr_pkg::SSSR_HOLD;
            cnt_r <= sssr_pkg::CNT_RST;
            target_r <= sssr_pkg::RESTART_CYCLES;
          end
        end
        default: begin
          state_r <= sssr_pkg::SSSR_OFF;
        end
      endcase
    end
  end

  assign fb_pullup_en = (state_r == sssr_pkg::SSSR_HOLD) ||
                        (state_r == sssr_pkg::SSSR_OFF);
  // switches off whenever the pull-up is on
  assign switch_enable = (state_r == sssr_pkg::SSSR_RUN);
  // analog oscillator starts at fmax and follows current
  assign start_at_fmax = (state_r == sssr_pkg::SSSR_WAIT);
  assign holdoff_active = fb_pullup_en;

  property p_excl;
    @(posedge sys_clk) disable iff (reset) !(switch_enable && fb_pullup_en);
  endproperty
  a_excl: assert property (p_excl) else $error("switch during pull-up");

  // check fault in run goes to hold-off
  property p_fault;
    @(posedge sys_clk) disable iff (reset)
      (state_r == sssr_pkg::SSSR_RUN && fault && sup_s)
        |=> fb_pullup_en && cnt_r == sssr_pkg::CNT_RST;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not honoured");

  property p_long;
    @(posedge sys_clk) disable iff (reset)
      (state_r == sssr_pkg::SSSR_HOLD && fault && sup_s)
        |=> target_r == sssr_pkg::RESTART_CYCLES;
  endproperty
  a_long: assert property (p_long) else $error("wrong long count");

  property p_short;
    @(posedge sys_clk) disable iff (reset)
      (state_r == sssr_pkg::SSSR_OFF && sup_s)
        |=> target_r == sssr_pkg::POWERUP_CYCLES;
  endproperty
  a_short: assert property (p_short) else $error("wrong power-up count");

  // check release only at full count
  property p_rel;
    @(posedge sys_clk) disable iff (reset)
      ($past(state_r) == sssr_pkg::SSSR_HOLD &&
       state_r == sssr_pkg::SSSR_WAIT)
        |-> $past(cnt_r) == $past(target_r) - 18'h00001;
  endproperty
  a_rel: assert property (p_rel) else $error("early release");

  // check counter moves only on ticks
  property p_tick;
    @(posedge sys_clk) disable iff (reset)
      (state_r == sssr_pkg::SSSR_HOLD && !fmax_tick && !fault &&
       sup_s)
        |=> $stable(cnt_r);
  endproperty
  a_tick: assert property (p_tick) else $error("count without tick");

  property p_sup;
    @(posedge sys_clk) disable iff (reset) !sup_s |=> fb_pullup_en;
  endproperty
  a_sup: assert property (p_sup) else $error("no pull-up unpowered");

  // check wait holds while limited and high
  property p_wait;
    @(posedge sys_clk) disable iff (reset)
      (state_r == sssr_pkg::SSSR_WAIT && lim_s && fb_hi_r && !fault &&
       sup_s)
        |=> !switch_enable;
  endproperty
  a_wait: assert property (p_wait) else $error("start above 2V");
endmodule

// >>> sssr_pkg.sv
// constants for the soft-start and restart sequencer
package sssr_pkg;
  localparam int CNT_W = 18;
  localparam logic [17:0] POWERUP_CYCLES = 18'h00400;
  localparam logic [17:0] RESTART_CYCLES = 18'h20000;
  localparam logic [2:0] OC_PULSES = 3'h7;
  localparam logic [2:0] OC_CNT_RST = 3'h0;
  localparam logic [17:0] CNT_RST = 18'h00000;
  typedef enum logic [1:0] {
    SSSR_OFF  = 2'b00,
    SSSR_HOLD = 2'b01,
    SSSR_WAIT = 2'b10,
    SSSR_RUN  = 2'b11
  } sssr_state_t;
endpackage

// >>> sssr_sync.sv
// three-stage synchroniser for asynchronous comparator levels
`timescale 1ns/10ps
module sssr_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// >>> test_sssr_core.sv
// self-checking bench for the soft-start and restart sequencer
`timescale 1ns/10ps
module test_sssr_core;
  typedef struct {
    logic line_low;
    logic cs_high;
    logic arq;
    int npulse;
    logic brk;
    logic trip;
  } sssr_row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic fmax_tick = 1'b1;
  logic supply_ok = 1'b1;
  logic line_voltage_ok = 1'b1;
  logic cs_pulse_low = 1'b0;
  logic cs_pulse_high = 1'b0;
  logic fb_current_limit = 1'b1;
  logic fb_above_2v0 = 1'b1;
  logic osc_cycle = 1'b0;
  logic autorestart_req = 1'b0;
  logic fb_pullup_en;
  logic switch_enable;
  logic start_at_fmax;
  logic holdoff_active;
  logic slow = 1'b0;
  logic sw_bad;
  int num_errors = 0;
  int tests_run = 0;
  int cnt;
  sssr_row_t rows [6];

  sssr_core sssr_core_i (
    .sys_clk(sys_clk),
    .reset(reset),
    .fmax_tick(fmax_tick),
    .supply_ok(supply_ok),
    .line_voltage_ok(line_voltage_ok),
    .cs_pulse_low(cs_pulse_low),
    .cs_pulse_high(cs_pulse_high),
    .fb_current_limit(fb_current_limit),
    .fb_above_2v0(fb_above_2v0),
    .osc_cycle(osc_cycle),
    .autorestart_req(autorestart_req),
    .fb_pullup_en(fb_pullup_en),
    .switch_enable(switch_enable),
    .start_at_fmax(start_at_fmax),
    .holdoff_active(holdoff_active)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // slow mode halves the fmax rate to show the count follows the tick
  always @(posedge sys_clk) fmax_tick <= #2 slow ? ~fmax_tick : 1'b1;

  task wrap_up;
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_rng(input int n, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  // range allows for the synchroniser latency ahead of the count
  task hold(output int n);
    sw_bad = 1'b0;
    n = 0;
    while (fb_pullup_en === 1'b1 && n < 140000) begin
      if (switch_enable !== 1'b0) sw_bad = 1'b1;
      cyc(1);
      n++;
    end
    chk(sw_bad, 1'b0);
  endtask

  task restore(input int lo, input int hi);
    supply_ok = 1'b0;
    cyc(10);
    chk(fb_pullup_en, 1'b1);
    supply_ok = 1'b1;
    cyc(1);
    hold(cnt);
    chk_rng(cnt, lo, hi);
    cyc(10);
    chk(switch_enable, 1'b1);
  endtask

  initial begin
    repeat (200000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    rows[0] = '{1'b1, 1'b0, 1'b0, 0, 1'b0, 1'b1};
    rows[1] = '{1'b0, 1'b1, 1'b0, 0, 1'b0, 1'b1};
    rows[2] = '{1'b0, 1'b0, 1'b1, 0, 1'b0, 1'b1};
    rows[3] = '{1'b0, 1'b0, 1'b0, 7, 1'b0, 1'b1};
    rows[4] = '{1'b0, 1'b0, 1'b0, 6, 1'b0, 1'b0};
    rows[5] = '{1'b0, 1'b0, 1'b0, 8, 1'b1, 1'b0};
    cyc(20);
    reset = 1'b0;
    hold(cnt);
    chk_rng(cnt, 1024, 1032);
    cyc(20);
    chk(fb_pullup_en, 1'b0);
    chk(start_at_fmax, 1'b1);
    chk(switch_enable, 1'b0);
    fb_above_2v0 = 1'b0;
    cyc(10);
    chk(switch_enable, 1'b1);
    chk(start_at_fmax, 1'b0);
    fb_current_limit = 1'b0;
    foreach (rows[r]) begin
      line_voltage_ok = !rows[r].line_low;
      cs_pulse_high = rows[r].cs_high;
      autorestart_req = rows[r].arq;
      cyc(1);
      autorestart_req = 1'b0;
      cyc(7);
      line_voltage_ok = 1'b1;
      cs_pulse_high = 1'b0;
      for (int i = 0; i < rows[r].npulse; i++) begin
        cs_pulse_low = 1'b1;
        cyc(6);
        cs_pulse_low = 1'b0;
        cyc(6);
        if (rows[r].brk && i == 3) begin
          osc_cycle = 1'b1;
          cyc(1);
          osc_cycle = 1'b0;
        end
      end
      cyc(10);
      chk(fb_pullup_en, rows[r].trip);
      chk(holdoff_active, rows[r].trip);
      chk(switch_enable, !rows[r].trip);
      restore(1024, 1032);
    end
    slow = 1'b1;
    restore(2048, 2064);
    slow = 1'b0;
    line_voltage_ok = 1'b0;
    cyc(8);
    line_voltage_ok = 1'b1;
    cyc(1000);
    chk(fb_pullup_en, 1'b1);
    cs_pulse_high = 1'b1;
    cyc(8);
    cs_pulse_high = 1'b0;
    hold(cnt);
    chk_rng(cnt, 131072, 131080);
    wrap_up();
  end
endmodule
